// ---- rtl/sadf_pkg.sv ----
// package: register map, field positions, reset values and timing for the stereo audio converter front end
package sadf_pkg;
   // register byte offsets on the axi4-lite bus
   localparam logic [4:0] SADF_OFF_CONTROL = 5'h00;  // audio_conv_control
   localparam logic [4:0] SADF_OFF_STATUS  = 5'h04;  // audio_conv_status
   localparam logic [4:0] SADF_OFF_DFLT    = 5'h08;  // underflow_sample_reg
   localparam logic [4:0] SADF_OFF_LEFT    = 5'h0C;  // left_sample_port
   localparam logic [4:0] SADF_OFF_RIGHT   = 5'h10;  // right_sample_port
   // control field positions
   localparam int SADF_CTL_ON     = 15;  // conv_module_on
   localparam int SADF_CTL_SIDL   = 13;  // halt_when_idle
   localparam int SADF_CTL_AMP    = 12;  // amp_keep_on_low_power
   localparam int SADF_CTL_SIGNED = 8;   // signed_sel
   localparam int SADF_DIV_W      = 7;   // conv_clock_divisor width
   // status field positions, left half; right half is eight lower
   localparam int SADF_ST_OE      = 15;  // output enable
   localparam int SADF_ST_MID     = 13;  // midpoint output enable
   localparam int SADF_ST_ITYPE   = 10;  // irq type
   localparam int SADF_ST_FULL    = 9;   // queue full
   localparam int SADF_ST_EMPTY   = 8;   // queue empty
   localparam int SADF_ST_RSHIFT  = 8;   // offset from left to right field
   // writable masks and reset values
   localparam logic [15:0] SADF_CTL_WMASK = 16'hB17F;
   localparam logic [15:0] SADF_CTL_RST   = 16'h0005;  // divide by 6
   localparam logic [15:0] SADF_ST_WMASK  = 16'hA4A4;
   localparam logic [15:0] SADF_ST_RST    = 16'h0000;
   localparam logic [15:0] SADF_DFLT_RST  = 16'h0000;
   localparam logic [15:0] SADF_MIDPOINT  = 16'h8000;
   // conversion timing
   localparam int SADF_OSR        = 256;  // converter clocks per sample
   localparam int SADF_QDEPTH     = 4;
   localparam int SADF_SAMPLE_W   = 16;
   // axi response codes
   localparam logic [1:0] SADF_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SADF_RESP_SLVERR = 2'h2;
   // decoded control settings
   typedef struct packed {
      logic                  module_on;
      logic                  halt_when_idle;
      logic                  amp_keep_on;
      logic                  signed_sel;
      logic [SADF_DIV_W-1:0] divisor;
   } sadf_ctl_t;
   // one channel's output-side controls
   typedef struct packed {
      logic out_enable;
      logic mid_enable;
      logic irq_type;
   } sadf_chan_t;
endpackage : sadf_pkg

// ---- rtl/sadf_queue.sv ----
// four-entry sample queue for one converter channel
`timescale 1ns/1ps
`default_nettype none
module sadf_queue
   import sadf_pkg::*;
#(
   parameter int DEPTH = SADF_QDEPTH,
   parameter int WIDTH = SADF_SAMPLE_W
)(
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   // fill side
   input  wire logic             i_push,
   input  wire logic [WIDTH-1:0] i_data,
   // drain side
   input  wire logic             i_pop,
   output logic      [WIDTH-1:0] o_data,
   // state
   output logic                  o_full,
   output logic                  o_empty
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];    // sample storage
   logic [AW-1:0]    wr_r;           // write pointer
   logic [AW-1:0]    rd_r;           // read pointer
   logic [AW:0]      cnt_r;          // occupancy
   wire              do_push = i_push && !o_full;   // writes to a full queue are dropped
   wire              do_pop  = i_pop && !o_empty;
   assign o_full  = (cnt_r == (AW+1)'(DEPTH));
   assign o_empty = (cnt_r == '0);
   assign o_data  = mem[rd_r];
   ////////////////////////////////////////////////////////////////
   // pointer and count update
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (do_push)
            wr_r <= wr_r + 1'b1;
         if (do_pop)
            rd_r <= rd_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
   // storage, no reset needed
   always_ff @(posedge i_clk)
   begin
      if (do_push)
         mem[wr_r] <= i_data;
   end
endmodule // sadf_queue
`default_nettype wire

// ---- rtl/sadf_clkdiv.sv ----
// converter clock divider and sample-instant counter, as enables on the system clock
`timescale 1ns/1ps
`default_nettype none
module sadf_clkdiv
   import sadf_pkg::*;
#(
   parameter int OSR = SADF_OSR
)(
   // clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   // control
   input  wire logic                  i_run,
   input  wire logic                  i_aux_tick,
   input  wire logic [SADF_DIV_W-1:0] i_divisor,
   // enables
   output logic                       o_conv_tick,
   output logic                       o_sample_tick
);
   logic [SADF_DIV_W-1:0]  div_r;   // prescale count
   logic [$clog2(OSR)-1:0] osr_r;   // converter clocks within one sample
   wire div_wrap = (div_r >= i_divisor);
   assign o_conv_tick   = i_run && i_aux_tick && div_wrap;
   assign o_sample_tick = o_conv_tick && (osr_r == '1);
   ////////////////////////////////////////////////////////////////
   // divide aux ticks by divisor plus one, then by the oversampling ratio
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || !i_run)
      begin
         div_r <= '0;
         osr_r <= '0;
      end
      else if (i_aux_tick)
      begin
         div_r <= div_wrap ? '0 : div_r + 1'b1;
         if (div_wrap)
            osr_r <= osr_r + 1'b1;
      end
   end
endmodule // sadf_clkdiv
`default_nettype wire

// ---- rtl/sadf_top.sv ----
// stereo audio converter front end: axi4-lite registers, sample queues, pacing and format
//
// Functional notes
// - separate four-entry queue per channel
// - empty queue at sample instant uses default
// - oversample by 256 with interpolated points
// - control bit 8 selects signed or unsigned
// - unsigned: 0x8000 is midpoint
// - signed: 0x0000 is midpoint
// - seven-bit divider, value plus one, reset six
// - one sample per 256 converter clocks
// - bit 13 halts conversion while idle
// - bit 12 keeps amplifier on in low power
// - status bits 13 and 5 enable midpoints
// - bus and dma both write samples
// - data port write with both low byte strobes enqueues the sample
// - default register is 16-bit, resets zero
`timescale 1ns/1ps
`default_nettype none
module sadf_top
   import sadf_pkg::*;
#(
   parameter int OSR = SADF_OSR
)(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // axi4-lite write address and data
   input  wire logic [4:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   // axi4-lite write response
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   // axi4-lite read
   input  wire logic [4:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // dma sample writes
   input  wire logic        i_dma_left_valid,
   input  wire logic        i_dma_right_valid,
   input  wire logic [15:0] i_dma_data,
   output logic             o_dma_left_ready,
   output logic             o_dma_right_ready,
   // system state and auxiliary oscillator tick
   input  wire logic        i_idle,
   input  wire logic        i_sleep,
   input  wire logic        i_aux_tick,
   // converter outputs
   output logic [15:0]      o_left_sample,
   output logic [15:0]      o_right_sample,
   output logic             o_sample_strobe,
   output logic             o_conv_tick,
   output logic             o_left_out_enable,
   output logic             o_right_out_enable,
   output logic             o_left_midpoint_out_enable,
   output logic             o_right_midpoint_out_enable,
   output logic             o_amp_enable,
   output logic             o_left_irq,
   output logic             o_right_irq
);
   ////////////////////////////////////////////////////////////////
   // register state
   logic [15:0] ctl_r;          // audio_conv_control
   logic [15:0] stat_r;         // writable part of audio_conv_status
   logic [15:0] dflt_r;         // underflow_sample_reg
   sadf_ctl_t   ctl;            // decoded control
   sadf_chan_t  left_cfg;       // left channel controls
   sadf_chan_t  right_cfg;      // right channel controls
   assign ctl       = '{ctl_r[SADF_CTL_ON], ctl_r[SADF_CTL_SIDL], ctl_r[SADF_CTL_AMP],
                        ctl_r[SADF_CTL_SIGNED], ctl_r[SADF_DIV_W-1:0]};
   assign left_cfg  = '{stat_r[SADF_ST_OE], stat_r[SADF_ST_MID], stat_r[SADF_ST_ITYPE]};
   assign right_cfg = '{stat_r[SADF_ST_OE-SADF_ST_RSHIFT], stat_r[SADF_ST_MID-SADF_ST_RSHIFT],
                        stat_r[SADF_ST_ITYPE-SADF_ST_RSHIFT]};

   ////////////////////////////////////////////////////////////////
   // axi write channel: address and data latched independently
   logic        aw_have_r;      // write address held
   logic        w_have_r;       // write data held
   logic [4:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   assign o_awready = !aw_have_r && !bvalid_r;
   assign o_wready  = !w_have_r && !bvalid_r;
   assign o_bvalid  = bvalid_r;
   assign o_bresp   = bresp_r;
   wire        wr_fire  = aw_have_r && w_have_r && !bvalid_r;
   wire        wr_lo    = w_strb_r[0];
   wire        wr_hi    = w_strb_r[1];
   wire        wr_ctl   = wr_fire && (aw_addr_r == SADF_OFF_CONTROL);
   wire        wr_stat  = wr_fire && (aw_addr_r == SADF_OFF_STATUS);
   wire        wr_dflt  = wr_fire && (aw_addr_r == SADF_OFF_DFLT);
   wire        wr_left  = wr_fire && (aw_addr_r == SADF_OFF_LEFT) && wr_lo && wr_hi;
   wire        wr_right = wr_fire && (aw_addr_r == SADF_OFF_RIGHT) && wr_lo && wr_hi;
   wire        wr_known = (aw_addr_r == SADF_OFF_CONTROL) || (aw_addr_r == SADF_OFF_STATUS) ||
                          (aw_addr_r == SADF_OFF_DFLT) || (aw_addr_r == SADF_OFF_LEFT) ||
                          (aw_addr_r == SADF_OFF_RIGHT);

   // merge byte lanes under a writable mask
   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                              input logic lo, input logic hi,
                                              input logic [15:0] mask);
      logic [15:0] nv;
      nv = old;
      if (lo)
         nv[7:0] = wd[7:0];
      if (hi)
         nv[15:8] = wd[15:8];
      return (nv & mask) | (old & ~mask);
   endfunction

   // axi write handshake
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         aw_addr_r <= '0;
         w_data_r  <= '0;
         w_strb_r  <= '0;
         bvalid_r  <= 1'b0;
         bresp_r   <= SADF_RESP_OKAY;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            aw_have_r <= 1'b1;
            aw_addr_r <= i_awaddr;
         end
         if (i_wvalid && o_wready)
         begin
            w_have_r <= 1'b1;
            w_data_r <= i_wdata;
            w_strb_r <= i_wstrb;
         end
         if (wr_fire)
         begin
            // both halves present: commit and answer
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_known ? SADF_RESP_OKAY : SADF_RESP_SLVERR;
         end
         else if (bvalid_r && i_bready)
            bvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // control, status and default registers
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         ctl_r  <= SADF_CTL_RST;
         stat_r <= SADF_ST_RST;
         dflt_r <= SADF_DFLT_RST;
      end
      else
      begin
         if (wr_ctl)
            ctl_r <= lane_merge(ctl_r, w_data_r, wr_lo, wr_hi, SADF_CTL_WMASK);
         if (wr_stat)
            stat_r <= lane_merge(stat_r, w_data_r, wr_lo, wr_hi, SADF_ST_WMASK);
         if (wr_dflt)
            dflt_r <= lane_merge(dflt_r, w_data_r, wr_lo, wr_hi, 16'hFFFF);
      end
   end

   ////////////////////////////////////////////////////////////////
   // pacing: converter clock and sample instants
   // halt while idle when asked
   wire run = ctl.module_on && !(i_idle && ctl.halt_when_idle);
   logic conv_tick;
   logic sample_tick;
   sadf_clkdiv #(
      .OSR (OSR)
   ) u_div (
      .i_clk         (i_clk),
      .i_rst_n       (i_rst_n),
      .i_run         (run),
      .i_aux_tick    (i_aux_tick),
      .i_divisor     (ctl.divisor),
      .o_conv_tick   (conv_tick),
      .o_sample_tick (sample_tick)
   );

   ////////////////////////////////////////////////////////////////
   // channel queues; the bus port has priority over dma
   logic [15:0] lq_data;
   logic [15:0] rq_data;
   logic        lq_full;
   logic        lq_empty;
   logic        rq_full;
   logic        rq_empty;
   // dma writes when bus port is quiet
   assign o_dma_left_ready  = !lq_full && !wr_left;
   assign o_dma_right_ready = !rq_full && !wr_right;
   wire         l_push = wr_left || (i_dma_left_valid && o_dma_left_ready);
   wire         r_push = wr_right || (i_dma_right_valid && o_dma_right_ready);
   wire [15:0]  l_in   = wr_left ? w_data_r[15:0] : i_dma_data;
   wire [15:0]  r_in   = wr_right ? w_data_r[15:0] : i_dma_data;

   sadf_queue u_lq (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_push  (l_push),
      .i_data  (l_in),
      .i_pop   (sample_tick),
      .o_data  (lq_data),
      .o_full  (lq_full),
      .o_empty (lq_empty)
   );
   sadf_queue u_rq (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_push  (r_push),
      .i_data  (r_in),
      .i_pop   (sample_tick),
      .o_data  (rq_data),
      .o_full  (rq_full),
      .o_empty (rq_empty)
   );

   ////////////////////////////////////////////////////////////////
   // format: signed input flips the sign bit to offset binary
   function automatic logic [15:0] to_offset(input logic [15:0] s, input logic sgn);
      return sgn ? (s ^ SADF_MIDPOINT) : s;
   endfunction
   wire [15:0] l_pick = lq_empty ? dflt_r : lq_data;
   wire [15:0] r_pick = rq_empty ? dflt_r : rq_data;

   // current sample held between sample instants, in offset binary
   logic [15:0] l_cur_r;
   logic [15:0] r_cur_r;
   logic [15:0] l_out_r;
   logic [15:0] r_out_r;
   logic [15:0] l_step_r;         // left interpolation increment (signed)
   logic [15:0] r_step_r;
   logic        strobe_r;
   // signed difference over OSR points, arithmetic shift
   function automatic logic [15:0] step_of(input logic [15:0] nxt, input logic [15:0] cur);
      logic signed [16:0] d;
      d = $signed({1'b0, nxt}) - $signed({1'b0, cur});
      return 16'(d >>> $clog2(OSR));
   endfunction
   wire [15:0] l_new = to_offset(l_pick, ctl.signed_sel);
   wire [15:0] r_new = to_offset(r_pick, ctl.signed_sel);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         l_cur_r  <= SADF_MIDPOINT;
         r_cur_r  <= SADF_MIDPOINT;
         l_out_r  <= SADF_MIDPOINT;
         r_out_r  <= SADF_MIDPOINT;
         l_step_r <= '0;
         r_step_r <= '0;
         strobe_r <= 1'b0;
      end
      else
      begin
         strobe_r <= sample_tick;
         if (sample_tick)
         begin
            l_cur_r  <= l_new;
            r_cur_r  <= r_new;
            l_out_r  <= l_cur_r;
            r_out_r  <= r_cur_r;
            l_step_r <= step_of(l_new, l_cur_r);
            r_step_r <= step_of(r_new, r_cur_r);
         end
         else if (conv_tick)
         begin
            l_out_r <= l_out_r + l_step_r;
            r_out_r <= r_out_r + r_step_r;
         end
      end
   end
   assign o_left_sample   = l_out_r;
   assign o_right_sample  = r_out_r;
   assign o_sample_strobe = strobe_r;
   assign o_conv_tick     = conv_tick;

   ////////////////////////////////////////////////////////////////
   // output enables and amplifier
   // module enable gates outputs
   assign o_left_out_enable  = ctl.module_on && left_cfg.out_enable;
   assign o_right_out_enable = ctl.module_on && right_cfg.out_enable;
   assign o_left_midpoint_out_enable  = ctl.module_on && left_cfg.mid_enable;
   assign o_right_midpoint_out_enable = ctl.module_on && right_cfg.mid_enable;
   // amplifier kept on in low power only when amp_keep_on is set
   wire low_power = i_sleep || (i_idle && ctl.halt_when_idle);
   assign o_amp_enable = ctl.module_on && (!low_power || ctl.amp_keep_on);
   // irq on empty or not full
   assign o_left_irq  = left_cfg.irq_type ? lq_empty : !lq_full;
   assign o_right_irq = right_cfg.irq_type ? rq_empty : !rq_full;

   ////////////////////////////////////////////////////////////////
   // axi read channel
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic [15:0] stat_view;
   always_comb
   begin
      stat_view = stat_r & SADF_ST_WMASK;
      stat_view[SADF_ST_FULL]                  = lq_full;
      stat_view[SADF_ST_EMPTY]                 = lq_empty;
      stat_view[SADF_ST_FULL-SADF_ST_RSHIFT]   = rq_full;
      stat_view[SADF_ST_EMPTY-SADF_ST_RSHIFT]  = rq_empty;
   end
   assign o_arready = !rvalid_r;
   assign o_rvalid  = rvalid_r;
   assign o_rdata   = rdata_r;
   assign o_rresp   = rresp_r;
   // read decode: data ports read zero
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= SADF_RESP_OKAY;
      end
      else if (i_arvalid && o_arready)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= SADF_RESP_OKAY;
         unique case (i_araddr)
            SADF_OFF_CONTROL : rdata_r <= {16'h0000, ctl_r};
            SADF_OFF_STATUS  : rdata_r <= {16'h0000, stat_view};
            SADF_OFF_DFLT    : rdata_r <= {16'h0000, dflt_r};
            SADF_OFF_LEFT,
            SADF_OFF_RIGHT   : rdata_r <= '0;
            default
            begin
               rdata_r <= '0;
               rresp_r <= SADF_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_r && i_rready)
         rvalid_r <= 1'b0;
   end
endmodule // sadf_top
`default_nettype wire

// ---- tb/sadf_checker.sv ----
// port-level assertions
`timescale 1ns/1ps
`default_nettype none
module sadf_checker
   import sadf_pkg::*;
(
   // watched top ports
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic        i_awvalid,
   input wire logic        o_awready,
   input wire logic        i_wvalid,
   input wire logic        o_wready,
   input wire logic [1:0]  o_bresp,
   input wire logic        o_bvalid,
   input wire logic        i_bready,
   input wire logic        i_arvalid,
   input wire logic        o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic        o_rvalid,
   input wire logic        i_rready,
   input wire logic        o_sample_strobe
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////
   a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
      else $error("late write response");
   a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response not held");
   a_bvalid_drop: assert property (o_bvalid && i_bready |=> !o_bvalid)
      else $error("write response repeated");
   a_write_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken while busy");
   a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("late read data");
   a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data not held");
   a_read_refused: assert property (o_rvalid |-> !o_arready)
      else $error("read taken while busy");
   a_rvalid_drop: assert property (o_rvalid && i_rready |=> !o_rvalid)
      else $error("read data repeated");
   // four converter clocks per sample in the bench
   a_strobe_gap: assert property (o_sample_strobe |=> !o_sample_strobe [*3])
      else $error("sample instants too close");
   c_strobe: cover property (o_sample_strobe);
   c_slverr: cover property (o_bvalid && o_bresp == SADF_RESP_SLVERR);
   c_rstall: cover property (o_rvalid && !i_rready);
endmodule // sadf_checker
`default_nettype wire

// ---- tb/sadf_dma_src.sv ----
// dma engine model
`timescale 1ns/1ps
`default_nettype none
module sadf_dma_src
   import sadf_pkg::*;
(
   // clock and command
   input  wire logic        i_clk,
   input  wire logic        i_start,
   input  wire logic [15:0] i_base,
   input  wire logic [2:0]  i_count,
   input  wire logic [1:0]  i_gap,
   // sample offer
   input  wire logic        i_ready,
   output logic             o_valid = 1'b0,
   output logic [15:0]      o_data = 16'h0000,
   output logic             o_busy = 1'b0
);
   logic [2:0]  left_r = 3'h0;     // words still to send
   logic [1:0]  wait_r = 2'h0;     // idle cycles before next offer
   logic [15:0] next_r = 16'h0000; // value of the next word
   always @(posedge i_clk)
   begin
      if (i_start)
         {o_valid, o_busy, left_r, o_data, next_r} <= {2'b11, i_count, i_base, i_base + 16'h0001};
      else if (o_valid && i_ready)
      begin
         // released data inverted so stale words show
         {o_valid, o_data, wait_r, left_r} <= {1'b0, ~o_data, i_gap, left_r - 3'h1};
         o_busy <= (left_r != 3'h1);
      end
      else if (o_busy && wait_r != 2'h0)
         wait_r <= wait_r - 2'h1;
      else if (o_busy && !o_valid)
         {o_valid, o_data, next_r} <= {1'b1, next_r, next_r + 16'h0001};
   end
endmodule // sadf_dma_src
`default_nettype wire

// ---- tb/sadf_top_tb.sv ----
// self-checking bench
`timescale 1ns/1ps
`default_nettype none
module sadf_top_tb
   import sadf_pkg::*;
;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0;
   logic i_rready = 1'b0, i_idle = 1'b0, i_sleep = 1'b0, i_aux_tick = 1'b0, start = 1'b0, psel = 1'b0;
   logic [4:0] i_awaddr = 5'h00, i_araddr = 5'h00;
   logic [31:0] i_wdata = 32'h00000000, o_rdata, v;
   logic [3:0] i_wstrb = 4'hF;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_dma_left_ready, o_dma_right_ready, pv, pbusy;
   logic o_sample_strobe, o_conv_tick, o_left_out_enable, o_right_out_enable, o_left_midpoint_out_enable;
   logic o_right_midpoint_out_enable, o_amp_enable, o_left_irq, o_right_irq;
   logic [1:0] o_bresp, o_rresp, r;
   logic [15:0] o_left_sample, o_right_sample, pd;
   wire logic i_dma_left_valid = pv & psel;
   wire logic i_dma_right_valid = pv & ~psel;
   wire logic [15:0] i_dma_data = pd;
   int err_count = 0, cmp_count = 0, k, n, c, t;
   // format rows: default word, expected output, signed bit
   localparam logic [15:0] FDV [6] = '{16'h8000, 16'h0000, 16'hFFFF, 16'h7FFF, 16'h8000, 16'h0000};
   localparam logic [15:0] FEX [6] = '{16'h8000, 16'h8000, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000};
   localparam logic [5:0] FSG = 6'b011010;
   // low-power rows: control, idle and sleep, amplifier
   localparam logic [15:0] LPC [4] = '{16'hA000, 16'hB000, 16'h8000, 16'h8000};
   localparam logic [1:0] LPW [4] = '{2'b10, 2'b10, 2'b01, 2'b10};
   localparam logic [3:0] LPA = 4'b1010;
   always #10 i_clk = ~i_clk;
   sadf_top #(.OSR(4)) i_dut (.*);
   sadf_dma_src i_src (.i_clk, .i_start(start), .i_base(16'h0200), .i_count(3'h4), .i_gap(2'h1),
      .i_ready(psel ? o_dma_left_ready : o_dma_right_ready), .o_valid(pv), .o_data(pd), .o_busy(pbusy));
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // a spent wait bound ends the run
   task automatic fail_wait;
      chk("wait bound", 0, 1);
      complete_run();
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge i_clk);
      {i_awaddr, i_wdata, i_awvalid, i_wvalid} <= {a, d, 2'b11};
      for (n = 0; n < 40; n++)
      begin
         @(posedge i_clk);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
         if (o_bvalid && i_bready) break;
         if (o_bvalid) i_bready <= 1'b1;
      end
      chk("bresp", er, o_bresp);
      i_bready <= 1'b0;
      if (n == 40) fail_wait();
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] rs);
      @(posedge i_clk);
      {i_araddr, i_arvalid} <= {a, 1'b1};
      for (n = 0; n < 40; n++)
      begin
         @(posedge i_clk);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
         if (o_rvalid && i_rready) break;
         if (o_rvalid) i_rready <= 1'b1;
      end
      {d, rs} = {o_rdata, o_rresp};
      i_rready <= 1'b0;
      if (n == 40) fail_wait();
   endtask
   task automatic rc(input logic [4:0] a, input logic [31:0] e, input string nm);
      rd(a, v, r);
      chk(nm, e, v);
      chk("rresp", SADF_RESP_OKAY, r);
   endtask
   // cycles and ticks to next strobe
   task automatic gap;
      t = 0;
      for (c = 1; c < 100; c++)
      begin
         @(posedge i_clk);
         t = t + int'(o_conv_tick);
         if (o_sample_strobe === 1'b1) break;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rc(SADF_OFF_CONTROL, 32'h00000005, "control");
      rc(SADF_OFF_STATUS, 32'h00000101, "status");
      rc(SADF_OFF_DFLT, 32'h00000000, "default");
      chk("irq", 2'b11, {o_left_irq, o_right_irq});
      rd(5'h14, v, r);
      chk("unmapped rresp", SADF_RESP_SLVERR, r);
      wr(5'h14, 32'h0000FFFF, SADF_RESP_SLVERR);
      wr(SADF_OFF_STATUS, 32'h0000FFFF, SADF_RESP_OKAY);
      rc(SADF_OFF_STATUS, 32'h0000A5A5, "status");
      chk("enables", 4'h0, {o_left_out_enable, o_right_out_enable, o_left_midpoint_out_enable,
         o_right_midpoint_out_enable});
      wr(SADF_OFF_CONTROL, 32'h00008000, SADF_RESP_OKAY);
      chk("enables", 4'hF, {o_left_out_enable, o_right_out_enable, o_left_midpoint_out_enable,
         o_right_midpoint_out_enable});
      // fifth bus word finds the queue full
      for (k = 0; k < 5; k++)
         wr(SADF_OFF_LEFT, 32'h00000100 + k, SADF_RESP_OKAY);
      @(posedge i_clk);
      start <= 1'b1;
      @(posedge i_clk);
      start <= 1'b0;
      for (k = 0; k < 60 && (k == 0 || pbusy !== 1'b0); k++) @(posedge i_clk);
      if (k == 60) fail_wait();
      chk("dma ready", 1'b0, o_dma_right_ready);
      rc(SADF_OFF_STATUS, 32'h0000A6A6, "status");
      chk("irq", 2'b00, {o_left_irq, o_right_irq});
      i_aux_tick <= 1'b1;
      for (k = 0; k < 6; k++)
      begin
         wr(SADF_OFF_DFLT, {16'h0000, FDV[k]}, SADF_RESP_OKAY);
         rc(SADF_OFF_DFLT, {16'h0000, FDV[k]}, "default");
         wr(SADF_OFF_CONTROL, {16'h0000, 7'h40, FSG[k], 8'h00}, SADF_RESP_OKAY);
         repeat (40) @(posedge i_clk);
         chk("left out", FEX[k], o_left_sample);
         chk("right out", FEX[k], o_right_sample);
      end
      rc(SADF_OFF_STATUS, 32'h0000A5A5, "status");
      wr(SADF_OFF_CONTROL, 32'h00008002, SADF_RESP_OKAY);
      gap();
      gap();
      chk("strobe gap", 12, c);
      chk("tick count", 4, t);
      for (k = 0; k < 4; k++)
      begin
         {i_idle, i_sleep} <= LPW[k];
         wr(SADF_OFF_CONTROL, {16'h0000, LPC[k]}, SADF_RESP_OKAY);
         chk("amp", LPA[k], o_amp_enable);
      end
      complete_run();
   end
endmodule // sadf_top_tb
bind sadf_top sadf_checker i_chk (.i_clk, .i_rst_n, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp,
   .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready, .o_sample_strobe);
`default_nettype wire
